// ===== logic/sct_top.sv
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "sct_defs.svh"
module sct_top #(
   parameter int BAUD_W = 13
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Avalon-MM slave
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Serial pins
   input wire logic i_rxd,
   input wire logic i_txd,
   output logic o_txd,
   output logic o_txd_oe,
   // System
   input wire logic i_cpu_wait,
   output logic o_irq
);
   //----------------------------------------
   // Registers and state
   //----------------------------------------
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [BAUD_W-1:0] baud_reg;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;
   logic wait_reg;
   logic tx_buffer_empty_flag_reg;
   logic tc_reg;
   logic tx_buffer_empty_flag_arm_reg;
   logic tc_arm_reg;
   logic [8:0] buf_reg;
   logic buf_full_reg;
   logic pre_pend_reg;
   logic brk_pend_reg;
   logic tx_idle_d_reg;
   sct_pkg::sct_tx_state_type tx_state_reg;
   logic [10:0] tx_shift_reg;
   logic [3:0] tx_bits_reg;
   logic [3:0] tx_sub_reg;
   logic [BAUD_W-1:0] div_reg;
   logic tick_reg;
   sct_pkg::sct_rx_state_type rx_state_reg;
   logic [3:0] rx_sub_reg;
   logic [3:0] rx_bits_reg;
   logic [8:0] rx_shift_reg;
   logic [8:0] rx_data_reg;
   logic rx_full_reg;
   logic rx_idle_flag_reg;
   logic [3:0] idle_cnt_reg;
   logic idle_armed_reg;
   logic rx_in_reg;

   //----------------------------------------
   // Decode
   //----------------------------------------
   logic acc;
   logic wr;
   logic rd;
   logic run;
   logic loop_mode;
   logic single_wire;
   logic len9;
   logic [3:0] frame_bits;
   logic wr_data;
   logic wr_ctrl2;
   logic rd_stat;
   logic rd_data;
   logic te_rise;
   logic sbk_q;
   logic tx_load;
   logic tx_from_buf;
   logic tx_busy;
   logic tx_idle_now;
   logic tx_buffer_empty_flag_set;
   logic tc_set;
   logic rx_line;
   logic rx_bit;
   logic rx_done;
   logic rx_stop_bit;
   logic idle_event;
   logic [3:0] irq_set;

   function automatic logic is_addr(input logic [3:0] a,
                                    input logic [3:0] off);
      is_addr = (a == off);
   endfunction : is_addr

   assign acc = (i_read | i_write) & ~wait_reg;
   assign wr = acc & i_write;
   assign rd = acc & i_read;
   assign wr_data = wr & is_addr(i_address, `SCT_OFF_DATA);
   assign wr_ctrl2 = wr & is_addr(i_address, `SCT_OFF_CTRL2);
   assign rd_stat = rd & is_addr(i_address, `SCT_OFF_STAT1);
   assign rd_data = rd & is_addr(i_address, `SCT_OFF_DATA);
   assign run = ~(ctrl1_reg[`SCT_C1_HALT] & i_cpu_wait);
   assign loop_mode = ctrl1_reg[`SCT_C1_LOOP];
   assign single_wire = loop_mode & ctrl1_reg[`SCT_C1_RECEIVER_SOURCE_SELECT];
   assign len9 = ctrl1_reg[`SCT_C1_LEN9];
   assign frame_bits = len9 ? `SCT_BITS_LONG : `SCT_BITS_SHORT;
   assign te_rise = wr_ctrl2 & i_writedata[`SCT_C2_TE]
                    & ~ctrl2_reg[`SCT_C2_TE];
   assign sbk_q = wr_ctrl2 & i_writedata[`SCT_C2_SBK];
   assign tx_busy = (tx_state_reg == sct_pkg::TX_SHIFT);
   assign tx_idle_now = ~tx_busy & ~buf_full_reg & ~pre_pend_reg
                        & ~brk_pend_reg;
   assign tx_load = ~tx_busy & run & ctrl2_reg[`SCT_C2_TE]
                    & (pre_pend_reg | brk_pend_reg | buf_full_reg);
   assign tx_from_buf = tx_load & ~pre_pend_reg & ~brk_pend_reg;
   assign tx_buffer_empty_flag_set = tx_from_buf;
   assign tc_set = tx_idle_now & ~tx_idle_d_reg;

   // Receiver input routing
   always_comb
   begin
      if (!loop_mode)
         rx_line = i_rxd;
      else if (single_wire)
         rx_line = i_txd;
      else
         rx_line = o_txd;
   end

   //----------------------------------------
   // Bus handshake and readback
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         wait_reg <= 1'b1;
      else if ((i_read | i_write) & wait_reg)
         wait_reg <= 1'b0;
      else
         wait_reg <= 1'b1;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         o_readdata <= 32'h0000_0000;
      else if (i_read & wait_reg)
      begin
         o_readdata <= 32'h0000_0000;
         case (i_address)
            `SCT_OFF_CTRL1: o_readdata[7:0] <= ctrl1_reg;
            `SCT_OFF_STAT1: o_readdata[7:0] <= {tx_buffer_empty_flag_reg, tc_reg,
               rx_full_reg, rx_idle_flag_reg, 4'h0};
            `SCT_OFF_DATA: o_readdata[8:0] <= rx_data_reg;
            `SCT_OFF_CTRL2: o_readdata[7:0] <= ctrl2_reg;
            `SCT_OFF_BAUD: o_readdata[BAUD_W-1:0] <= baud_reg;
            `SCT_OFF_IRQ_STAT: o_readdata[3:0] <= irq_stat_reg;
            `SCT_OFF_IRQ_MASK: o_readdata[3:0] <= irq_mask_reg;
            default: o_readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_comb o_waitrequest = wait_reg;

   //----------------------------------------
   // Control registers
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         ctrl1_reg <= `SCT_C1_RESET;
      else if (wr & is_addr(i_address, `SCT_OFF_CTRL1))
         ctrl1_reg <= {i_writedata[7:2], 2'b00};
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         ctrl2_reg <= 8'h00;
      else if (wr_ctrl2)
         ctrl2_reg <= {1'b0, i_writedata[6], 2'b00, i_writedata[3],
                       1'b0, i_writedata[1], 1'b0};
      else if (idle_event & ~ctrl1_reg[`SCT_C1_WAKE])
         ctrl2_reg[`SCT_C2_RWU] <= 1'b0;
      else if (rx_done & ctrl1_reg[`SCT_C1_WAKE] & rx_stop_bit
               & (len9 ? rx_shift_reg[8] : rx_shift_reg[7]))
         ctrl2_reg[`SCT_C2_RWU] <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         baud_reg <= `SCT_BAUD_RESET;
      else if (wr & is_addr(i_address, `SCT_OFF_BAUD))
         baud_reg <= i_writedata[BAUD_W-1:0];
   end

   //----------------------------------------
   // Transmit flags
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         tx_buffer_empty_flag_arm_reg <= 1'b0;
      else if (rd_stat)
         tx_buffer_empty_flag_arm_reg <= tx_buffer_empty_flag_reg;
      else if (wr_data)
         tx_buffer_empty_flag_arm_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         tc_arm_reg <= 1'b0;
      else if (rd_stat)
         tc_arm_reg <= tc_reg;
      else if (wr_data | te_rise | sbk_q)
         tc_arm_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         tx_buffer_empty_flag_reg <= 1'b1;
      else if (tx_buffer_empty_flag_set)
         tx_buffer_empty_flag_reg <= 1'b1;
      else if (wr_data & tx_buffer_empty_flag_arm_reg)
         tx_buffer_empty_flag_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         tc_reg <= 1'b1;
      else if (tc_set)
         tc_reg <= 1'b1;
      else if (tc_arm_reg & (wr_data | te_rise | sbk_q))
         tc_reg <= 1'b0;
      else if (tx_busy)
         tc_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         tx_idle_d_reg <= 1'b1;
      else
         tx_idle_d_reg <= tx_idle_now;
   end

   //----------------------------------------
   // Transmit buffer and queues
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         buf_reg <= 9'h000;
      else if (wr_data)
         buf_reg <= {ctrl2_reg[`SCT_C2_TX9], i_writedata[7:0]};
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         buf_full_reg <= 1'b0;
      else if (wr_data)
         buf_full_reg <= 1'b1;
      else if (tx_from_buf)
         buf_full_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         pre_pend_reg <= 1'b0;
      else if (te_rise)
         pre_pend_reg <= 1'b1;
      else if (tx_load)
         pre_pend_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         brk_pend_reg <= 1'b0;
      else if (sbk_q)
         brk_pend_reg <= 1'b1;
      else if (tx_load & ~pre_pend_reg)
         brk_pend_reg <= 1'b0;
   end

   //----------------------------------------
   // Oversample clock enable
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end
      else if (!run || baud_reg == '0)
         tick_reg <= 1'b0;
      else if (div_reg >= baud_reg - 1'b1)
      begin
         div_reg <= '0;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   //----------------------------------------
   // Transmit shifter
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         tx_state_reg <= sct_pkg::TX_IDLE;
         tx_shift_reg <= 11'h7FF;
         tx_bits_reg <= 4'h0;
         tx_sub_reg <= 4'h0;
         o_txd <= 1'b1;
      end
      else
      begin
         case (tx_state_reg)
            sct_pkg::TX_IDLE:
            begin
               o_txd <= 1'b1;
               if (tx_load)
               begin
                  tx_state_reg <= sct_pkg::TX_SHIFT;
                  tx_bits_reg <= frame_bits;
                  tx_sub_reg <= 4'h0;
                  if (pre_pend_reg)
                     tx_shift_reg <= 11'h7FF;
                  else if (brk_pend_reg)
                     tx_shift_reg <= 11'h000;
                  else if (len9)
                     tx_shift_reg <= {1'b1, buf_reg, 1'b0};
                  else
                     tx_shift_reg <= {2'b11, buf_reg[7:0], 1'b0};
               end
            end
            sct_pkg::TX_SHIFT:
            begin
               o_txd <= tx_shift_reg[0];
               if (tick_reg)
               begin
                  tx_sub_reg <= tx_sub_reg + 1'b1;
                  if (tx_sub_reg == 4'hF)
                  begin
                     tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                     tx_bits_reg <= tx_bits_reg - 1'b1;
                     if (tx_bits_reg == 4'h1)
                        tx_state_reg <= sct_pkg::TX_IDLE;
                  end
               end
            end
            default: tx_state_reg <= sct_pkg::TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         o_txd_oe <= 1'b0;
      else
         o_txd_oe <= ctrl2_reg[`SCT_C2_TE] | tx_busy;
   end

   //----------------------------------------
   // Receiver
   //----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         rx_in_reg <= 1'b1;
      else
         rx_in_reg <= rx_line;
   end

   assign rx_bit = tick_reg & (rx_sub_reg == 4'hF);
   assign rx_done = (rx_state_reg == sct_pkg::RX_DATA) & rx_bit
                    & (rx_bits_reg == 4'h1);
   assign rx_stop_bit = rx_in_reg;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         rx_state_reg <= sct_pkg::RX_IDLE;
         rx_sub_reg <= 4'h0;
         rx_bits_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
      end
      else if (tick_reg)
      begin
         rx_sub_reg <= rx_sub_reg + 1'b1;
         case (rx_state_reg)
            sct_pkg::RX_IDLE:
               if (!rx_in_reg)
               begin
                  rx_state_reg <= sct_pkg::RX_START;
                  rx_sub_reg <= 4'h0;
               end
            sct_pkg::RX_START:
               if (rx_sub_reg == `SCT_MID_SAMPLE)
               begin
                  rx_sub_reg <= 4'h0;
                  rx_bits_reg <= frame_bits - 4'h1;
                  rx_state_reg <= rx_in_reg ? sct_pkg::RX_IDLE
                                            : sct_pkg::RX_DATA;
               end
            sct_pkg::RX_DATA:
               if (rx_sub_reg == 4'hF)
               begin
                  rx_bits_reg <= rx_bits_reg - 1'b1;
                  if (rx_bits_reg == 4'h1)
                     rx_state_reg <= sct_pkg::RX_IDLE;
                  else if (len9)
                     rx_shift_reg <= {rx_in_reg, rx_shift_reg[8:1]};
                  else
                     rx_shift_reg <= {1'b0, rx_in_reg,
                                      rx_shift_reg[7:1]};
               end
            default: rx_state_reg <= sct_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         rx_data_reg <= 9'h000;
         rx_full_reg <= 1'b0;
      end
      else if (rx_done & ~ctrl2_reg[`SCT_C2_RWU])
      begin
         rx_data_reg <= rx_shift_reg;
         rx_full_reg <= 1'b1;
      end
      else if (rd_data)
         rx_full_reg <= 1'b0;
   end

   //----------------------------------------
   // Idle line counting
   //----------------------------------------
   assign idle_event = rx_bit & rx_in_reg & idle_armed_reg
                       & (idle_cnt_reg == frame_bits - 4'h1);

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         idle_cnt_reg <= 4'h0;
      else if (rx_state_reg == sct_pkg::RX_START)
         idle_cnt_reg <= 4'h0;
      else if (rx_bit)
      begin
         if (!rx_in_reg)
            idle_cnt_reg <= 4'h0;
         else if (rx_state_reg == sct_pkg::RX_DATA
                  && ctrl1_reg[`SCT_C1_ILT])
            idle_cnt_reg <= 4'h0;
         else if (idle_cnt_reg != frame_bits)
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         idle_armed_reg <= 1'b0;
      else if (rx_state_reg == sct_pkg::RX_DATA)
         idle_armed_reg <= 1'b1;
      else if (idle_event)
         idle_armed_reg <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         rx_idle_flag_reg <= 1'b0;
      else if (idle_event)
         rx_idle_flag_reg <= 1'b1;
      else if (rd_data)
         rx_idle_flag_reg <= 1'b0;
   end

   //----------------------------------------
   // Interrupts
   //----------------------------------------
   assign irq_set = {idle_event, rx_done & ~ctrl2_reg[`SCT_C2_RWU],
                     tc_set, tx_buffer_empty_flag_set};

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         irq_stat_reg <= 4'h0;
      else if (wr & is_addr(i_address, `SCT_OFF_IRQ_STAT))
         irq_stat_reg <= (irq_stat_reg & ~i_writedata[3:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         irq_mask_reg <= 4'h0;
      else if (wr & is_addr(i_address, `SCT_OFF_IRQ_MASK))
         irq_mask_reg <= i_writedata[3:0];
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         o_irq <= 1'b0;
      else
         o_irq <= |(irq_stat_reg & irq_mask_reg);
   end
endmodule : sct_top

// ===== pkg/sct_defs.svh
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH
// Register byte offsets
`define SCT_OFF_CTRL1 4'h0
`define SCT_OFF_STAT1 4'h1
`define SCT_OFF_DATA 4'h2
`define SCT_OFF_CTRL2 4'h3
`define SCT_OFF_BAUD 4'h4
`define SCT_OFF_IRQ_STAT 4'h5
`define SCT_OFF_IRQ_MASK 4'h6
// Control one fields
`define SCT_C1_LOOP 7
`define SCT_C1_HALT 6
`define SCT_C1_RECEIVER_SOURCE_SELECT 5
`define SCT_C1_LEN9 4
`define SCT_C1_WAKE 3
`define SCT_C1_ILT 2
`define SCT_C1_RESET 8'h00
// Status one fields
`define SCT_S1_TX_BUFFER_EMPTY_FLAG 7
`define SCT_S1_TC 6
`define SCT_S1_RXF 5
`define SCT_S1_IDLE 4
// Control two fields
`define SCT_C2_TX9 6
`define SCT_C2_TE 3
`define SCT_C2_RWU 1
`define SCT_C2_SBK 0
// Interrupt status bits
`define SCT_IRQ_TX_BUFFER_EMPTY_FLAG 0
`define SCT_IRQ_TC 1
`define SCT_IRQ_RXF 2
`define SCT_IRQ_IDLE 3
// Timing
`define SCT_OVERSAMPLE 5'h10
`define SCT_MID_SAMPLE 4'h7
`define SCT_BITS_SHORT 4'hA
`define SCT_BITS_LONG 4'hB
`define SCT_BAUD_RESET 13'h0001
`endif

// ===== pkg/sct_pkg.sv
package sct_pkg;
   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } sct_tx_state_type;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10
   } sct_rx_state_type;
endpackage : sct_pkg

// ===== sim/sct_chk.sv
`timescale 1ns/1ps
module sct_chk #(
   parameter int BAUD_W = 13
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Register bus
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   // Serial and system
   input wire logic i_rxd,
   input wire logic i_txd,
   input wire logic o_txd,
   input wire logic o_txd_oe,
   input wire logic i_cpu_wait,
   input wire logic o_irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // ---------------------------------------------
   // Bus handshake
   // ---------------------------------------------
   wait_one_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low for more than one cycle");
   req_answer_a: assert property (
      (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("request not answered after one cycle");
   idle_wait_a: assert property (!(i_read || i_write) |=> o_waitrequest)
      else $error("waitrequest low without request");
   reset_out_a: assert property (disable iff (1'b0) !i_rst_b |=>
      o_waitrequest && o_txd && !o_txd_oe && !o_irq && o_readdata == 0)
      else $error("outputs not at reset level");
   unmapped_a: assert property (
      i_read && !o_waitrequest && i_address > 4'h6 |-> o_readdata == 0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!i_read |=> $stable(o_readdata))
      else $error("read data moved without read");
   // ---------------------------------------------
   // Serial line and interrupt mask
   // ---------------------------------------------
   idle_high_a: assert property (!o_txd_oe |-> o_txd)
      else $error("transmit pin low while not driven");
   low_bit_a: assert property ($fell(o_txd) |->
      (!o_txd) [*8] ##1 (!o_txd) [*8]) else $error("low bit too short");
   high_bit_a: assert property ($rose(o_txd) && o_txd_oe |->
      o_txd [*8] ##1 o_txd [*8]) else $error("high bit too short");
   irq_mask_a: assert property (i_write && !o_waitrequest &&
      i_address == 4'h6 && i_writedata[3:0] == 4'h0 |=> ##1 !o_irq)
      else $error("masked interrupt still high");
endmodule : sct_chk
bind sct_top sct_chk #(.BAUD_W(BAUD_W)) u_chk (.i_mclk(i_mclk),
   .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
   .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
   .o_waitrequest(o_waitrequest), .i_rxd(i_rxd), .i_txd(i_txd),
   .o_txd(o_txd), .o_txd_oe(o_txd_oe), .i_cpu_wait(i_cpu_wait),
   .o_irq(o_irq));

// ===== sim/sct_peer.sv
`timescale 1ns/1ps
module sct_peer #(
   parameter int BIT = 16
) (
   input wire logic i_clk,
   input wire logic i_line,
   input wire logic i_len9,
   output logic o_rxd
);
   int rx_q[$];
   initial o_rxd = 1'b1;
   // ---------------------------------------------
   // Receiver: data bits then stop bit into one word
   // ---------------------------------------------
   initial
   begin : rx_proc
      int v;
      int i;
      forever
      begin
         @(posedge i_clk iff i_line === 1'b0);
         repeat (BIT / 2) @(posedge i_clk);
         v = 0;
         for (i = 0; i < (i_len9 ? 10 : 9); i++)
         begin
            repeat (BIT) @(posedge i_clk);
            v[i] = i_line;
         end
         rx_q.push_back(v);
         wait (i_line === 1'b1);
      end
   end
   // Sender: start, LSB first, stop, then idle high
   task automatic send(input int v, input int nb);
      int i;
      int bits;
      bits = (v << 1) | (1 << (nb + 1));
      for (i = 0; i < nb + 2; i++)
      begin
         @(posedge i_clk);
         o_rxd <= bits[i];
         repeat (BIT - 1) @(posedge i_clk);
      end
   endtask : send
endmodule : sct_peer

// ===== sim/sct_top_tb_top.sv
`timescale 1ns/1ps
`include "sct_defs.svh"
module sct_top_tb_top;
   logic clk, rst_b, rd, wr, cpu_wait, len9, waitreq, txd, txd_oe, irq, b;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, rv;
   wire logic line;
   wire logic rxd;
   int bad_count, n_checks;
   int exp_q[$];
   assign line = txd_oe ? txd : 1'b1;
   sct_top #(.BAUD_W(13)) dut (.i_mclk(clk), .i_rst_b(rst_b),
      .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
      .o_readdata(rdata), .o_waitrequest(waitreq), .i_rxd(rxd),
      .i_txd(line), .o_txd(txd), .o_txd_oe(txd_oe),
      .i_cpu_wait(cpu_wait), .o_irq(irq));
   sct_peer #(.BIT(16)) peer (.i_clk(clk), .i_line(line), .i_len9(len9),
      .o_rxd(rxd));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      #400000;
      bad_count++;
      test_done();
   end
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_reg
   task automatic cmp_char;
      int n;
      int got;
      int exp;
      n = 0;
      while (peer.rx_q.size() == 0 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      got = (n < 4000) ? peer.rx_q.pop_front() : -1;
      exp = exp_q.pop_front();
      n_checks++;
      if (got != exp)
      begin
         bad_count++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_char
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (waitreq !== 1'b0 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 50)
         bad_count++;
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic wait_stat(input int bit_n);
      int n;
      n = 0;
      rv = 0;
      while (rv[bit_n] !== 1'b1 && n < 400)
      begin
         bus(1'b0, `SCT_OFF_STAT1, 0);
         n++;
      end
      if (n == 400)
         bad_count++;
   endtask : wait_stat
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      int m, k, d, mode;
      rst_b = 1'b0;
      addr = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 0;
      cpu_wait = 1'b1;
      len9 = 1'b0;
      void'($urandom(32'h4055_9d17));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, `SCT_OFF_CTRL1, 0);
      cmp_reg(rv, 0);
      bus(1'b0, `SCT_OFF_STAT1, 0);
      cmp_reg(rv[7:0] & 8'hC0, 8'hC0);
      bus(1'b1, 4'hF, 32'h0000_00FF);
      bus(1'b0, 4'hF, 0);
      cmp_reg(rv, 0);
      bus(1'b0, `SCT_OFF_CTRL1, 0);
      cmp_reg(rv, 0);
      // Preamble on enable, clocks running in wait
      bus(1'b0, `SCT_OFF_STAT1, 0);
      bus(1'b1, `SCT_OFF_CTRL2, 8'h08);
      bus(1'b0, `SCT_OFF_STAT1, 0);
      cmp_reg(rv[7:0] & 8'hC0, 8'h80);
      wait_stat(6);
      cmp_reg(peer.rx_q.size(), 0);
      for (m = 0; m < 2; m++)
      begin
         len9 <= m[0];
         bus(1'b1, `SCT_OFF_CTRL1, 32'(m) << 4);
         for (k = 0; k < 2; k++)
         begin
            d = $urandom_range(0, m ? 511 : 255);
            bus(1'b1, `SCT_OFF_CTRL2, 8'h08 | 32'((d >> 8) << 6));
            wait_stat(7);
            bus(1'b1, `SCT_OFF_DATA, 32'(d & 255));
            exp_q.push_back(d | (1 << (8 + m)));
         end
         bus(1'b0, `SCT_OFF_STAT1, 0);
         cmp_reg(rv[7:0] & 8'hC0, 8'h00);
         cmp_char();
         cmp_char();
         wait_stat(6);
         cmp_reg(rv[7:0] & 8'hC0, 8'hC0);
      end
      len9 <= 1'b0;
      bus(1'b1, `SCT_OFF_CTRL1, 0);
      bus(1'b0, `SCT_OFF_STAT1, 0);
      bus(1'b1, `SCT_OFF_CTRL2, 8'h09);
      bus(1'b0, `SCT_OFF_STAT1, 0);
      cmp_reg(rv[7:0] & 8'h40, 8'h00);
      exp_q.push_back(0);
      cmp_char();
      wait_stat(6);
      // Receive source for each loop and source setting
      for (mode = 0; mode < 4; mode++)
      begin
         bus(1'b1, `SCT_OFF_CTRL1, 32'(((mode & 2) << 6) | ((mode & 1) << 5)));
         k = $urandom_range(0, 255);
         d = $urandom_range(0, 255);
         wait_stat(7);
         fork
            peer.send(k, 8);
            bus(1'b1, `SCT_OFF_DATA, 32'(d));
         join
         wait_stat(5);
         bus(1'b0, `SCT_OFF_DATA, 0);
         cmp_reg(rv & 32'h0000_00FF, mode > 1 ? d : k);
         wait_stat(6);
         repeat (40) @(posedge clk);
         peer.rx_q.delete();
      end
      // Idle count start point for both count types
      for (m = 0; m < 2; m++)
      begin
         bus(1'b1, `SCT_OFF_CTRL1, 32'(m) << 2);
         repeat (200) @(posedge clk);
         bus(1'b0, `SCT_OFF_DATA, 0);
         peer.send(255, 8);
         repeat (40) @(posedge clk);
         bus(1'b0, `SCT_OFF_STAT1, 0);
         cmp_reg(rv[4], m ? 0 : 1);
         wait_stat(4);
         bus(1'b0, `SCT_OFF_DATA, 0);
         cmp_reg(rv & 32'h0000_01FF, 32'h0000_00FF);
      end
      // Wakeup by address mark, then by idle line
      for (k = 0; k < 3; k++)
      begin
         bus(1'b1, `SCT_OFF_CTRL1, k < 2 ? 8'h08 : 8'h00);
         if (k != 1)
            bus(1'b1, `SCT_OFF_CTRL2, 8'h0A);
         d = $urandom_range(0, 127) | (k == 1 ? 128 : 0);
         peer.send(d, 8);
         repeat (300) @(posedge clk);
         bus(1'b0, `SCT_OFF_CTRL2, 0);
         cmp_reg(rv[1], k ? 0 : 1);
      end
      // Interrupt raise, mask and clear
      bus(1'b1, `SCT_OFF_IRQ_MASK, 8'h02);
      repeat (3) @(posedge clk);
      cmp_reg(irq, 1);
      bus(1'b1, `SCT_OFF_IRQ_MASK, 8'h00);
      repeat (3) @(posedge clk);
      cmp_reg(irq, 0);
      bus(1'b1, `SCT_OFF_IRQ_STAT, 8'h0F);
      bus(1'b1, `SCT_OFF_IRQ_MASK, 8'h02);
      repeat (3) @(posedge clk);
      cmp_reg(irq, 0);
      // Freeze in wait
      cpu_wait <= 1'b0;
      bus(1'b1, `SCT_OFF_CTRL1, 8'h40);
      wait_stat(7);
      bus(1'b1, `SCT_OFF_DATA, 8'h0F);
      repeat (60) @(posedge clk);
      cpu_wait <= 1'b1;
      repeat (3) @(posedge clk);
      b = txd;
      k = 0;
      repeat (100)
      begin
         @(posedge clk);
         if (txd !== b)
            k++;
      end
      cmp_reg(k, 0);
      bus(1'b0, `SCT_OFF_STAT1, 0);
      cmp_reg(rv[7:0] & 8'h40, 8'h00);
      cpu_wait <= 1'b0;
      wait_stat(6);
      test_done();
   end
endmodule : sct_top_tb_top
